// ### rtl/btfe_pkg.sv
// Purpose: Shared constants and types for the branch, trap and flag execution unit.
// Assumes: 16-bit words, byte addresses, 20 MHz processor clock.
// Notes:   Register offsets are AHB byte addresses of aligned 32-bit words.
`default_nettype none
package btfe_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] OFS_INSTR  = 8'h00;
	localparam logic [7:0] OFS_DEST   = 8'h04;
	localparam logic [7:0] OFS_STAT   = 8'h08;
	localparam logic [7:0] OFS_PSW    = 8'h0C;
	localparam logic [7:0] OFS_RESULT = 8'h10;
	localparam logic [2:0] GPR_PAGE   = 3'h1;
	localparam int         STAT_BUSY  = 0;
	localparam int         STAT_HALT  = 1;
	localparam int         STAT_WAIT  = 2;
	localparam int         STAT_INIT  = 3;
	localparam int         STAT_TINH  = 4;
	localparam int         STAT_TAKEN = 5;
	localparam int         STAT_ILL   = 6;
	// ==========================================================
	// Status word fields and register indices
	localparam int         PSW_C      = 0;
	localparam int         PSW_V      = 1;
	localparam int         PSW_Z      = 2;
	localparam int         PSW_N      = 3;
	localparam int         INSTR_SET  = 4;
	localparam logic [2:0] SP_IDX     = 3'h6;
	localparam logic [2:0] PC_IDX     = 3'h7;
	localparam logic [2:0] MODE_REG   = 3'h0;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	// ==========================================================
	// Opcodes
	localparam logic [6:0]  OP_XOR_HI  = 7'h3C;
	localparam logic [6:0]  OP_SOB_HI  = 7'h3F;
	localparam logic [6:0]  OP_JSR_HI  = 7'h04;
	localparam logic [12:0] OP_RTS_HI  = 13'h0010;
	localparam logic [12:0] OP_SPL_HI  = 13'h0013;
	localparam logic [10:0] OP_CC_HI   = 11'h005;
	localparam logic [7:0]  OP_EMT_HI  = 8'h88;
	localparam logic [7:0]  OP_TRAP_HI = 8'h89;
	localparam logic [15:0] OP_HALT    = 16'h0000;
	localparam logic [15:0] OP_WAIT    = 16'h0001;
	localparam logic [15:0] OP_RTI     = 16'h0002;
	localparam logic [15:0] OP_IOT     = 16'h0004;
	localparam logic [15:0] OP_RESET   = 16'h0005;
	localparam logic [15:0] OP_RTT     = 16'h0006;
	localparam logic [3:0]  BR_NONE    = 4'h0;
	// ==========================================================
	// Trap vectors
	localparam logic [15:0] VEC_IOT  = 16'h0010;
	localparam logic [15:0] VEC_EMT  = 16'h0018;
	localparam logic [15:0] VEC_TRAP = 16'h001C;
	// ==========================================================
	// Timing
	localparam int CLK_HZ      = 20000000;
	localparam int INIT_MS     = 20;
	localparam int MS_PER_S    = 1000;
	localparam int INIT_CYCLES = INIT_MS * CLK_HZ / MS_PER_S;
	localparam int CNT_W       = 19;
	// ==========================================================
	// Bus
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic       HRESP_OKAY = 1'b0;
	// ==========================================================
	// Types
	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} btfe_mem_t;
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} btfe_ap_t;
	typedef enum logic [10:0] {
		S_IDLE   = 11'h001,
		S_PUSH_A = 11'h002,
		S_PUSH_B = 11'h004,
		S_VEC_A  = 11'h008,
		S_VEC_B  = 11'h010,
		S_POP_A  = 11'h020,
		S_POP_B  = 11'h040,
		S_JSR    = 11'h080,
		S_RTS    = 11'h100,
		S_INIT   = 11'h200,
		S_STOP   = 11'h400
	} btfe_state_t;
endpackage
`default_nettype wire

// ### rtl/btfe_exec.sv
// Purpose: Executes program-control, trap, miscellaneous and flag instructions.
// Assumes: Memory partner answers each request with a one-cycle MEM_ACK on CLK.
// Notes:   Software loads registers and PC (already advanced), then writes INSTR.
`default_nettype none
module btfe_exec #(
	parameter int INIT_CYCLES = btfe_pkg::INIT_CYCLES
) (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output var  logic [31:0] HRDATA,
	output var  logic        HREADYOUT,
	output var  logic        HRESP,
	output var  logic        MEM_REQ,
	output var  logic        MEM_WE,
	output var  logic [15:0] MEM_ADDR,
	output var  logic [15:0] MEM_WDATA,
	input  wire logic [15:0] MEM_RDATA,
	input  wire logic        MEM_ACK,
	input  wire logic        IRQ_PIN,
	input  wire logic        CONSOLE_RUN,
	output var  logic        BUS_INIT,
	output var  logic        BUS_RELEASED,
	output var  logic        HALTED
);
	// ==========================================================
	// Declarations
	btfe_pkg::btfe_state_t state_r;
	btfe_pkg::btfe_mem_t mem_r;
	btfe_pkg::btfe_ap_t  ap_r;
	logic [15:0]         regs_r [8];
	logic [15:0]         psw_r;
	logic [15:0]         instr_r;
	logic [15:0]         dest_r;
	logic [15:0]         result_r;
	logic [15:0]         vec_r;
	logic [2:0]          link_r;
	logic                go_r;
	logic                init_r;
	logic                halted_r;
	logic                released_r;
	logic                trace_inh_r;
	logic                taken_r;
	logic                illegal_r;
	logic [btfe_pkg::CNT_W-1:0] init_cnt_r;
	logic                irq_meta_r;
	logic                irq_sync_r;
	logic                con_meta_r;
	logic                con_sync_r;
	logic [31:0]         hrdata_r;
	logic [31:0]         rd_nxt;
	logic                hreadyout_r;
	logic                bus_wr;
	logic                ap_take;
	logic [15:0]         sp;
	logic [15:0]         pc;
	logic [15:0]         sp_dec;
	logic [15:0]         sp_inc;
	logic [15:0]         xor_res;
	logic [15:0]         sob_res;
	logic [15:0]         br_target;
	logic [15:0]         sob_target;
	logic [3:0]          br_code;
	logic                is_branch;
	logic                br_ok;
	logic [6:0]          stat_word;

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge CLK) begin
		if (RST) begin
			irq_meta_r <= 1'b0;
			irq_sync_r <= 1'b0;
			con_meta_r <= 1'b0;
			con_sync_r <= 1'b0;
		end else begin
			irq_meta_r <= IRQ_PIN;
			irq_sync_r <= irq_meta_r;
			con_meta_r <= CONSOLE_RUN;
			con_sync_r <= con_meta_r;
		end
	end

	// ==========================================================
	// Operand and condition logic
	assign sp         = regs_r[btfe_pkg::SP_IDX];
	assign pc         = regs_r[btfe_pkg::PC_IDX];
	assign sp_dec     = sp - btfe_pkg::WORD_STEP;
	assign sp_inc     = sp + btfe_pkg::WORD_STEP;
	assign xor_res    = regs_r[instr_r[8:6]] ^ ((instr_r[5:3] == btfe_pkg::MODE_REG) ? regs_r[instr_r[2:0]] : dest_r);
	assign sob_res    = regs_r[instr_r[8:6]] - 16'h0001;
	assign sob_target = pc - {9'h000, instr_r[5:0], 1'b0};
	assign br_target  = pc + {{7{instr_r[7]}}, instr_r[7:0], 1'b0};
	assign br_code    = {instr_r[15], instr_r[10:8]};
	assign is_branch  = (instr_r[14:11] == 4'h0) && (br_code != btfe_pkg::BR_NONE);

	always_comb begin
		unique case (br_code)
			4'h1: br_ok = 1'b1;
			4'h2: br_ok = !psw_r[btfe_pkg::PSW_Z];
			4'h3: br_ok = psw_r[btfe_pkg::PSW_Z];
			4'h4: br_ok = psw_r[btfe_pkg::PSW_N] == psw_r[btfe_pkg::PSW_V];
			4'h5: br_ok = psw_r[btfe_pkg::PSW_N] ^ psw_r[btfe_pkg::PSW_V];
			4'h6: br_ok = !psw_r[btfe_pkg::PSW_Z]
				&& (psw_r[btfe_pkg::PSW_N] == psw_r[btfe_pkg::PSW_V]);
			4'h7: br_ok = psw_r[btfe_pkg::PSW_Z]
				|| (psw_r[btfe_pkg::PSW_N] ^ psw_r[btfe_pkg::PSW_V]);
			4'h8: br_ok = !psw_r[btfe_pkg::PSW_N];
			4'h9: br_ok = psw_r[btfe_pkg::PSW_N];
			4'hA: br_ok = !(psw_r[btfe_pkg::PSW_C] || psw_r[btfe_pkg::PSW_Z]);
			4'hB: br_ok = psw_r[btfe_pkg::PSW_C] || psw_r[btfe_pkg::PSW_Z];
			4'hC: br_ok = !psw_r[btfe_pkg::PSW_V];
			4'hD: br_ok = psw_r[btfe_pkg::PSW_V];
			4'hE: br_ok = !psw_r[btfe_pkg::PSW_C];
			4'hF: br_ok = psw_r[btfe_pkg::PSW_C];
			default: br_ok = 1'b0;
		endcase
	end

	// ==========================================================
	// AHB-Lite slave
	// Zero wait states keep the slave simple; a read issued right after a write
	// to the same register returns the value from before that write.
	assign ap_take   = HSEL && HTRANS[1] && HREADY && (HSIZE == btfe_pkg::HSIZE_WORD);
	assign bus_wr    = ap_r.valid && ap_r.write;
	assign stat_word = {illegal_r, taken_r, trace_inh_r, init_r, released_r, halted_r, state_r != btfe_pkg::S_IDLE};

	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (HADDR[7:5] == btfe_pkg::GPR_PAGE) begin
			rd_nxt[15:0] = regs_r[HADDR[4:2]];
		end else begin
			unique case (HADDR[7:0])
				btfe_pkg::OFS_INSTR:  rd_nxt[15:0] = instr_r;
				btfe_pkg::OFS_DEST:   rd_nxt[15:0] = dest_r;
				btfe_pkg::OFS_STAT:   rd_nxt[6:0]  = stat_word;
				btfe_pkg::OFS_PSW:    rd_nxt[15:0] = psw_r;
				btfe_pkg::OFS_RESULT: rd_nxt[15:0] = result_r;
				default:              rd_nxt       = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			ap_r        <= '0;
			hrdata_r    <= 32'h0000_0000;
			hreadyout_r <= 1'b1;
		end else begin
			hreadyout_r <= 1'b1;
			if (HREADY) begin
				ap_r <= '{ap_take, HWRITE, HADDR[7:0]};
			end
			hrdata_r <= (ap_take && !HWRITE) ? rd_nxt : 32'h0000_0000;
		end
	end

	// ==========================================================
	// Execution engine
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_r     <= btfe_pkg::S_IDLE;
			for (int i = 0; i < 8; i++) begin
				regs_r[i] <= 16'h0000;
			end
			psw_r       <= 16'h0000;
			instr_r     <= 16'h0000;
			dest_r      <= 16'h0000;
			result_r    <= 16'h0000;
			vec_r       <= 16'h0000;
			link_r      <= 3'h0;
			mem_r       <= '0;
			go_r        <= 1'b0;
			init_r      <= 1'b0;
			init_cnt_r  <= '0;
			halted_r    <= 1'b0;
			released_r  <= 1'b0;
			trace_inh_r <= 1'b0;
			taken_r     <= 1'b0;
			illegal_r   <= 1'b0;
		end else begin
			go_r <= 1'b0;
			unique case (state_r)
				btfe_pkg::S_IDLE: begin
					if (go_r) begin
						taken_r   <= 1'b0;
						illegal_r <= 1'b0;
						if (instr_r[15:9] == btfe_pkg::OP_XOR_HI) begin
							if (instr_r[5:3] == btfe_pkg::MODE_REG) begin
								regs_r[instr_r[2:0]] <= xor_res;
							end
							result_r                  <= xor_res;
							psw_r[btfe_pkg::PSW_N]   <= xor_res[15];
							psw_r[btfe_pkg::PSW_Z]   <= (xor_res == 16'h0000);
							psw_r[btfe_pkg::PSW_V]   <= 1'b0;
						end else if (instr_r[15:9] == btfe_pkg::OP_SOB_HI) begin
							regs_r[instr_r[8:6]] <= sob_res;
							if (sob_res != 16'h0000) begin
								regs_r[btfe_pkg::PC_IDX] <= sob_target;
								taken_r                  <= 1'b1;
							end
						end else if (is_branch) begin
							if (br_ok) begin
								regs_r[btfe_pkg::PC_IDX] <= br_target;
								taken_r                  <= 1'b1;
							end
						end else if (instr_r[15:9] == btfe_pkg::OP_JSR_HI) begin
							regs_r[btfe_pkg::SP_IDX] <= sp_dec;
							link_r                   <= instr_r[8:6];
							mem_r   <= '{1'b1, 1'b1, sp_dec, regs_r[instr_r[8:6]]};
							state_r <= btfe_pkg::S_JSR;
						end else if (instr_r[15:3] == btfe_pkg::OP_RTS_HI) begin
							regs_r[btfe_pkg::PC_IDX] <= regs_r[instr_r[2:0]];
							link_r                   <= instr_r[2:0];
							mem_r   <= '{1'b1, 1'b0, sp, 16'h0000};
							state_r <= btfe_pkg::S_RTS;
						end else if (instr_r[15:3] == btfe_pkg::OP_SPL_HI) begin
							psw_r[7:5] <= instr_r[2:0];
						end else if (instr_r[15:5] == btfe_pkg::OP_CC_HI) begin
							if (instr_r[btfe_pkg::INSTR_SET]) begin
								psw_r[3:0] <= psw_r[3:0] | instr_r[3:0];
							end else begin
								psw_r[3:0] <= psw_r[3:0] & ~instr_r[3:0];
							end
						end else if (instr_r == btfe_pkg::OP_IOT || instr_r[15:8] == btfe_pkg::OP_EMT_HI
							|| instr_r[15:8] == btfe_pkg::OP_TRAP_HI) begin
							if (instr_r == btfe_pkg::OP_IOT) begin
								vec_r <= btfe_pkg::VEC_IOT;
							end else if (instr_r[15:8] == btfe_pkg::OP_EMT_HI) begin
								vec_r <= btfe_pkg::VEC_EMT;
							end else begin
								vec_r <= btfe_pkg::VEC_TRAP;
							end
							regs_r[btfe_pkg::SP_IDX] <= sp_dec;
							mem_r   <= '{1'b1, 1'b1, sp_dec, psw_r};
							state_r <= btfe_pkg::S_PUSH_A;
						end else if (instr_r == btfe_pkg::OP_RTI || instr_r == btfe_pkg::OP_RTT) begin
							trace_inh_r <= (instr_r == btfe_pkg::OP_RTT);
							mem_r       <= '{1'b1, 1'b0, sp, 16'h0000};
							state_r     <= btfe_pkg::S_POP_A;
						end else if (instr_r == btfe_pkg::OP_RESET) begin
							init_r     <= 1'b1;
							init_cnt_r <= '0;
							state_r    <= btfe_pkg::S_INIT;
						end else if (instr_r == btfe_pkg::OP_HALT) begin
							halted_r <= 1'b1;
							state_r  <= btfe_pkg::S_STOP;
						end else if (instr_r == btfe_pkg::OP_WAIT) begin
							released_r <= 1'b1;
							state_r    <= btfe_pkg::S_STOP;
						end else begin
							illegal_r <= 1'b1;
						end
					end else if (bus_wr) begin
						if (ap_r.addr[7:5] == btfe_pkg::GPR_PAGE) begin
							regs_r[ap_r.addr[4:2]] <= HWDATA[15:0];
						end else if (ap_r.addr == btfe_pkg::OFS_INSTR) begin
							instr_r <= HWDATA[15:0];
							go_r    <= 1'b1;
						end else if (ap_r.addr == btfe_pkg::OFS_DEST) begin
							dest_r <= HWDATA[15:0];
						end else if (ap_r.addr == btfe_pkg::OFS_PSW) begin
							psw_r <= HWDATA[15:0];
						end
					end
				end
				btfe_pkg::S_JSR: begin
					if (MEM_ACK) begin
						mem_r.req                <= 1'b0;
						regs_r[link_r]           <= pc;
						regs_r[btfe_pkg::PC_IDX] <= dest_r;
						state_r                  <= btfe_pkg::S_IDLE;
					end
				end
				btfe_pkg::S_RTS: begin
					if (MEM_ACK) begin
						mem_r.req                <= 1'b0;
						regs_r[link_r]           <= MEM_RDATA;
						regs_r[btfe_pkg::SP_IDX] <= sp_inc;
						state_r                  <= btfe_pkg::S_IDLE;
					end
				end
				btfe_pkg::S_PUSH_A: begin
					if (MEM_ACK) begin
						regs_r[btfe_pkg::SP_IDX] <= sp_dec;
						mem_r   <= '{1'b1, 1'b1, sp_dec, pc};
						state_r <= btfe_pkg::S_PUSH_B;
					end
				end
				btfe_pkg::S_PUSH_B: begin
					if (MEM_ACK) begin
						mem_r   <= '{1'b1, 1'b0, vec_r, 16'h0000};
						state_r <= btfe_pkg::S_VEC_A;
					end
				end
				btfe_pkg::S_VEC_A: begin
					if (MEM_ACK) begin
						regs_r[btfe_pkg::PC_IDX] <= MEM_RDATA;
						mem_r   <= '{1'b1, 1'b0, vec_r + btfe_pkg::WORD_STEP, 16'h0000};
						state_r <= btfe_pkg::S_VEC_B;
					end
				end
				btfe_pkg::S_VEC_B: begin
					if (MEM_ACK) begin
						mem_r.req <= 1'b0;
						psw_r     <= MEM_RDATA;
						state_r   <= btfe_pkg::S_IDLE;
					end
				end
				btfe_pkg::S_POP_A: begin
					if (MEM_ACK) begin
						regs_r[btfe_pkg::PC_IDX] <= MEM_RDATA;
						regs_r[btfe_pkg::SP_IDX] <= sp_inc;
						mem_r   <= '{1'b1, 1'b0, sp_inc, 16'h0000};
						state_r <= btfe_pkg::S_POP_B;
					end
				end
				btfe_pkg::S_POP_B: begin
					if (MEM_ACK) begin
						mem_r.req                <= 1'b0;
						psw_r                    <= MEM_RDATA;
						regs_r[btfe_pkg::SP_IDX] <= sp_inc;
						state_r                  <= btfe_pkg::S_IDLE;
					end
				end
				btfe_pkg::S_INIT: begin
					init_cnt_r <= init_cnt_r + 1'b1;
					if (init_cnt_r == btfe_pkg::CNT_W'(INIT_CYCLES - 1)) begin
						init_r  <= 1'b0;
						state_r <= btfe_pkg::S_IDLE;
					end
				end
				btfe_pkg::S_STOP: begin
					if (halted_r && con_sync_r) begin
						halted_r <= 1'b0;
						state_r  <= btfe_pkg::S_IDLE;
					end else if (released_r && irq_sync_r) begin
						released_r <= 1'b0;
						state_r    <= btfe_pkg::S_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Outputs
	assign HRDATA       = hrdata_r;
	assign HREADYOUT    = hreadyout_r;
	assign HRESP        = btfe_pkg::HRESP_OKAY;
	assign MEM_REQ      = mem_r.req;
	assign MEM_WE       = mem_r.we;
	assign MEM_ADDR     = mem_r.addr;
	assign MEM_WDATA    = mem_r.wdata;
	assign BUS_INIT     = init_r;
	assign BUS_RELEASED = released_r;
	assign HALTED       = halted_r;
endmodule
`default_nettype wire

// ### test/btfe_exec_props.sv
// Purpose: Port-level temporal checks for the execution unit.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Attached to every instance by the bind at the foot.
`default_nettype none
module btfe_exec_props #(
	parameter int INIT_CYCLES = 16
) (
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        HSEL,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic        HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic        HREADYOUT,
	input wire logic        HRESP,
	input wire logic        MEM_REQ,
	input wire logic        MEM_WE,
	input wire logic [15:0] MEM_ADDR,
	input wire logic [15:0] MEM_WDATA,
	input wire logic        MEM_ACK,
	input wire logic        IRQ_PIN,
	input wire logic        CONSOLE_RUN,
	input wire logic        BUS_INIT,
	input wire logic        BUS_RELEASED,
	input wire logic        HALTED
);
	// ==========
	// Helper state
	int   init_cnt;
	logic rd_ph;
	default clocking dc @(posedge CLK); endclocking
	default disable iff (RST);
	// The width is counted here because a repetition of the full count would be far too long to unroll.
	always_ff @(posedge CLK) begin
		if (RST) begin
			init_cnt <= 0;
			rd_ph    <= 1'b0;
		end else begin
			init_cnt <= BUS_INIT ? init_cnt + 1 : 0;
			rd_ph    <= HSEL && HTRANS[1] && HREADY && !HWRITE;
		end
	end
	// ==========
	// Memory traffic steps
	sequence s_wr_done;
		MEM_REQ && MEM_WE && MEM_ACK;
	endsequence
	sequence s_rd_done;
		MEM_REQ && !MEM_WE && MEM_ACK;
	endsequence
	a_bus_okay: assert property (HREADYOUT && HRESP == btfe_pkg::HRESP_OKAY)
		else $error("bus answer not zero-wait OKAY");
	a_rdata_idle: assert property (!rd_ph |-> HRDATA == 32'h0)
		else $error("read data outside a data phase");
	a_req_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable({MEM_WE, MEM_ADDR, MEM_WDATA}))
		else $error("memory request changed before ack");
	a_push_step: assert property (s_wr_done ##1 (MEM_REQ && MEM_WE) |-> MEM_ADDR == $past(MEM_ADDR) - 16'h0002)
		else $error("second push not two below first");
	a_vec_addr: assert property (s_wr_done ##1 (MEM_REQ && !MEM_WE) |-> MEM_ADDR inside
		{btfe_pkg::VEC_IOT, btfe_pkg::VEC_EMT, btfe_pkg::VEC_TRAP})
		else $error("vector fetch from wrong location");
	a_pop_step: assert property (s_rd_done ##1 (MEM_REQ && !MEM_WE) |-> MEM_ADDR == $past(MEM_ADDR) + 16'h0002)
		else $error("second read not two above first");
	a_init_width: assert property ($fell(BUS_INIT) |-> init_cnt == INIT_CYCLES)
		else $error("bus initialize pulse too short");
	a_init_limit: assert property (BUS_INIT |-> init_cnt < INIT_CYCLES)
		else $error("bus initialize pulse too long");
	a_halt_quiet: assert property (HALTED |-> !MEM_REQ)
		else $error("memory traffic while halted");
	a_halt_hold: assert property (!CONSOLE_RUN [*4] ##0 HALTED |=> HALTED)
		else $error("halt left without console action");
	a_halt_wake: assert property (HALTED && $rose(CONSOLE_RUN) |-> ##[1:4] !HALTED)
		else $error("console restart ignored");
	a_wait_quiet: assert property (BUS_RELEASED |-> !MEM_REQ)
		else $error("memory traffic while waiting");
	a_wait_wake: assert property (BUS_RELEASED && $rose(IRQ_PIN) |-> ##[1:4] !BUS_RELEASED)
		else $error("interrupt did not end the wait");
endmodule
bind btfe_exec btfe_exec_props #(.INIT_CYCLES(INIT_CYCLES)) u_btfe_exec_props (
	.CLK, .RST, .HSEL, .HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .MEM_REQ, .MEM_WE,
	.MEM_ADDR, .MEM_WDATA, .MEM_ACK, .IRQ_PIN, .CONSOLE_RUN, .BUS_INIT, .BUS_RELEASED, .HALTED
);
`default_nettype wire

// ### test/btfe_mem_model.sv
// Purpose: Memory holding stack and vectors, answering after LAT idle cycles.
// Assumes: Words at even byte addresses below 512.
// Notes:   The bench loads and inspects the array directly.
`default_nettype none
module btfe_mem_model (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic [3:0]  LAT,
	input  wire logic        MEM_REQ,
	input  wire logic        MEM_WE,
	input  wire logic [15:0] MEM_ADDR,
	input  wire logic [15:0] MEM_WDATA,
	output var  logic [15:0] MEM_RDATA,
	output var  logic        MEM_ACK
);
	logic [15:0] mem [0:255];
	logic [3:0]  wait_r;
	// Read data flips every cycle without a request and in each cycle after an ack, so a fetch that misses the ack cycle gets garbage.
	always @(posedge CLK) begin
		if (RST || MEM_ACK || !MEM_REQ) begin
			MEM_ACK   <= 1'b0;
			MEM_RDATA <= RST ? 16'hA5A5 : ~MEM_RDATA;
			wait_r    <= 4'h0;
		end else if (wait_r == LAT) begin
			MEM_ACK <= 1'b1;
			wait_r  <= 4'h0;
			if (MEM_WE) begin
				mem[MEM_ADDR[8:1]] <= MEM_WDATA;
			end else begin
				MEM_RDATA <= mem[MEM_ADDR[8:1]];
			end
		end else begin
			wait_r <= wait_r + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ### test/branch_trap_flag_exec_tb_top.sv
// Purpose: Self-checking bench driving instructions through the register bus.
// Assumes: Zero-wait slave, memory model on the far side.
// Notes:   Bus initialize count shortened to INIT cycles.
`default_nettype none
module branch_trap_flag_exec_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int INIT = 16;
	logic        CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, IRQ_PIN, CONSOLE_RUN;
	logic        MEM_REQ, MEM_WE, MEM_ACK, BUS_INIT, BUS_RELEASED, HALTED;
	logic [31:0] HADDR, HWDATA, HRDATA;
	logic [1:0]  HTRANS;
	logic [2:0]  HSIZE;
	logic [15:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, x, pc;
	logic [3:0]  lat;
	int          errors, checked, cyc, n;
	logic [7:0]  bc [15] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
		8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87};
	logic [15:0] top [5] = '{btfe_pkg::OP_IOT, 16'h8800, 16'h88FF, 16'h8900, 16'h89FF};
	logic [15:0] tv [5] = '{btfe_pkg::VEC_IOT, btfe_pkg::VEC_EMT, btfe_pkg::VEC_EMT,
		btfe_pkg::VEC_TRAP, btfe_pkg::VEC_TRAP};
	btfe_exec #(.INIT_CYCLES(INIT)) u_btfe_exec (.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
		.HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .MEM_REQ, .MEM_WE, .MEM_ADDR, .MEM_WDATA,
		.MEM_RDATA, .MEM_ACK, .IRQ_PIN, .CONSOLE_RUN, .BUS_INIT, .BUS_RELEASED, .HALTED);
	btfe_mem_model u_btfe_mem_model (.CLK, .RST, .LAT(lat), .MEM_REQ, .MEM_WE, .MEM_ADDR, .MEM_WDATA,
		.MEM_RDATA, .MEM_ACK);
	// ==========
	// Clock and hang guard
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			results();
		end
	end
	// ==========
	// Tasks
	task automatic results();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// One idle cycle closes every transfer, so no strobe is driven twice in one step.
	task automatic ahb(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
		HSEL   <= 1'b1;
		HTRANS <= 2'h2;
		HADDR  <= {24'h0, a};
		HWRITE <= w;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= {16'h0, d};
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		q = HRDATA[15:0];
		HSEL <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		ahb(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string m);
		logic [15:0] q;
		ahb(1'b0, a, 16'h0, q);
		cmp(q, e, m);
	endtask
	task automatic poll();
		logic [15:0] q;
		n = 0;
		do begin
			ahb(1'b0, btfe_pkg::OFS_STAT, 16'h0, q);
			n++;
		end while (q[btfe_pkg::STAT_BUSY] !== 1'b0 && n < 200);
		cmp(16'(q[btfe_pkg::STAT_BUSY]), 16'h0000, "busy timeout");
	endtask
	task automatic exec(input logic [15:0] op);
		wr(btfe_pkg::OFS_INSTR, op);
		poll();
	endtask
	function automatic logic [7:0] ga(input int i);
		return {btfe_pkg::GPR_PAGE, i[2:0], 2'b00};
	endfunction
	function automatic logic tk(input logic [7:0] c, input logic [3:0] f);
		case (c)
			8'h01: tk = 1'b1;
			8'h02: tk = !f[2];
			8'h03: tk = f[2];
			8'h04: tk = f[3] == f[1];
			8'h05: tk = f[3] ^ f[1];
			8'h06: tk = !f[2] && f[3] == f[1];
			8'h07: tk = f[2] || (f[3] ^ f[1]);
			8'h80: tk = !f[3];
			8'h81: tk = f[3];
			8'h82: tk = !(f[0] || f[2]);
			8'h83: tk = f[0] || f[2];
			8'h84: tk = !f[1];
			8'h85: tk = f[1];
			8'h86: tk = !f[0];
			default: tk = f[0];
		endcase
	endfunction
	// ==========
	// Main sequence
	initial begin
		RST = 1'b1;
		HSEL = 1'b0;
		HADDR = 32'h0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = btfe_pkg::HSIZE_WORD;
		HWDATA = 32'h0;
		IRQ_PIN = 1'b0;
		CONSOLE_RUN = 1'b0;
		lat = 4'h0;
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		rdc(btfe_pkg::OFS_PSW, 16'h0000, "status word reset");
		rdc(ga(6), 16'h0000, "stack pointer reset");
		wr(8'h14, 16'hFFFF);
		rdc(8'h14, 16'h0000, "unmapped read");
		wr(btfe_pkg::OFS_STAT, 16'hFFFF);
		rdc(btfe_pkg::OFS_STAT, 16'h0000, "status read-only");
		for (int k = 0; k < 16; k++) begin
			wr(btfe_pkg::OFS_PSW, 16'h0005);
			exec(16'h00B0 | k[15:0]);
			rdc(btfe_pkg::OFS_PSW, 16'h0005 | k[15:0], "flag set");
			exec(16'h00A0 | k[15:0]);
			rdc(btfe_pkg::OFS_PSW, 16'h0005 & ~k[15:0], "flag clear");
		end
		for (int b = 0; b < 15; b++) begin
			for (int f = 0; f < 16; f++) begin
				x = f[0] ? 16'h0080 : 16'h007F;
				wr(btfe_pkg::OFS_PSW, 16'(f));
				wr(ga(7), 16'h1000);
				exec({bc[b], x[7:0]});
				pc = 16'h1000 + (tk(bc[b], f[3:0]) ? {{7{x[7]}}, x[7:0], 1'b0} : 16'h0000);
				rdc(ga(7), pc, "branch target");
			end
		end
		wr(ga(2), 16'h0002);
		for (int s = 0; s < 2; s++) begin
			wr(ga(7), 16'h1000);
			exec({btfe_pkg::OP_SOB_HI, 3'h2, 6'h3F});
			rdc(ga(2), 16'h0001 - s[15:0], "loop count");
			rdc(ga(7), s ? 16'h1000 : 16'h0F82, "loop target");
		end
		wr(btfe_pkg::OFS_PSW, 16'h0003);
		wr(ga(3), 16'h8F0F);
		for (int e = 0; e < 2; e++) begin
			wr(ga(4), e ? 16'h8F0F : 16'h0F0F);
			exec({btfe_pkg::OP_XOR_HI, 3'h3, btfe_pkg::MODE_REG, 3'h4});
			rdc(ga(4), e ? 16'h0000 : 16'h8000, "xor result");
			rdc(btfe_pkg::OFS_PSW, e ? 16'h0005 : 16'h0009, "xor flags");
		end
		wr(btfe_pkg::OFS_PSW, 16'h0000);
		for (int p = 0; p < 8; p++) begin
			exec({btfe_pkg::OP_SPL_HI, p[2:0]});
			rdc(btfe_pkg::OFS_PSW, {8'h00, p[2:0], 5'h00}, "priority");
		end
		lat <= 4'h3;
		wr(ga(6), 16'h0100);
		wr(ga(5), 16'h1234);
		wr(ga(7), 16'h2000);
		wr(btfe_pkg::OFS_DEST, 16'h3000);
		exec({btfe_pkg::OP_JSR_HI, 3'h5, 6'h37});
		cmp(u_btfe_mem_model.mem[8'h7F], 16'h1234, "pushed link");
		rdc(ga(5), 16'h2000, "link register");
		rdc(ga(7), 16'h3000, "call target");
		rdc(ga(6), 16'h00FE, "stack after call");
		exec({btfe_pkg::OP_RTS_HI, 3'h5});
		rdc(ga(7), 16'h2000, "return pc");
		rdc(ga(5), 16'h1234, "restored link");
		rdc(ga(6), 16'h0100, "stack after return");
		for (int t = 0; t < 5; t++) begin
			lat <= t[0] ? 4'h3 : 4'h0;
			u_btfe_mem_model.mem[tv[t][8:1]] = 16'h4000 + t[15:0];
			u_btfe_mem_model.mem[tv[t][8:1] + 8'h01] = 16'h00E0 + t[15:0];
			wr(ga(6), 16'h0100);
			wr(ga(7), 16'h2000 + t[15:0]);
			wr(btfe_pkg::OFS_PSW, 16'h00E5);
			exec(top[t]);
			cmp(u_btfe_mem_model.mem[8'h7F], 16'h00E5, "pushed status");
			cmp(u_btfe_mem_model.mem[8'h7E], 16'h2000 + t[15:0], "pushed pc");
			rdc(ga(7), 16'h4000 + t[15:0], "vector pc");
			rdc(btfe_pkg::OFS_PSW, 16'h00E0 + t[15:0], "vector status");
			rdc(ga(6), 16'h00FC, "stack after trap");
		end
		for (int r = 0; r < 2; r++) begin
			wr(ga(6), 16'h00FC);
			u_btfe_mem_model.mem[8'h7E] = 16'h2468;
			u_btfe_mem_model.mem[8'h7F] = 16'h000A;
			exec(r ? btfe_pkg::OP_RTT : btfe_pkg::OP_RTI);
			rdc(ga(7), 16'h2468, "popped pc");
			rdc(btfe_pkg::OFS_PSW, 16'h000A, "popped status");
			rdc(ga(6), 16'h0100, "stack after pops");
			ahb(1'b0, btfe_pkg::OFS_STAT, 16'h0, x);
			cmp(16'(x[btfe_pkg::STAT_TINH]), 16'(r), "trace inhibit");
		end
		wr(btfe_pkg::OFS_INSTR, btfe_pkg::OP_RESET);
		n = 0;
		while (BUS_INIT !== 1'b1 && n < 10) begin
			@(posedge CLK);
			n++;
		end
		n = 0;
		while (BUS_INIT === 1'b1 && n < 100) begin
			@(posedge CLK);
			n++;
		end
		cmp(16'(n), 16'(INIT), "initialize width");
		poll();
		for (int h = 0; h < 2; h++) begin
			wr(btfe_pkg::OFS_INSTR, h ? btfe_pkg::OP_WAIT : btfe_pkg::OP_HALT);
			repeat (10) @(posedge CLK);
			cmp(16'(h ? BUS_RELEASED : HALTED), 16'h0001, "stopped");
			if (h) IRQ_PIN <= 1'b1;
			else CONSOLE_RUN <= 1'b1;
			repeat (5) @(posedge CLK);
			cmp(16'(h ? BUS_RELEASED : HALTED), 16'h0000, "resumed");
			IRQ_PIN <= 1'b0;
			CONSOLE_RUN <= 1'b0;
			@(posedge CLK);
		end
		results();
	end
endmodule
`default_nettype wire
